// ===== rtl/irq_route_idle_wake.v
// first-level interrupt routing and idle-wake logic with an AHB-Lite register slave
// assumes one 50 MHz clock, async active-low reset, source lines asynchronous to hclk
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.vh"

module irq_route_idle_wake #(
   parameter NUM_SRC = 32
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire [NUM_SRC-1:0] irq_src,
   input wire idle_mode,
   output reg cpu_irq,
   output reg cpu_fiq,
   output reg idle_wake,
   output wire evt_irq
);

   reg [31:0] mask_ff;
   reg [31:0] route_ff;
   reg ctl_dim_ff;
   reg [`EVT_WIDTH-1:0] evt_status_ff;
   reg [`EVT_WIDTH-1:0] evt_mask_ff;
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [`ADDR_BITS-1:0] addr_ff;
   reg [`ADDR_BITS-1:0] nxt_addr;
   reg cpu_irq_d_ff;
   reg cpu_fiq_d_ff;
   reg wake_d_ff;
   reg [31:0] nxt_rdata;
   reg [`EVT_WIDTH-1:0] nxt_evt_status;
   wire [NUM_SRC-1:0] src_sync;
   wire [31:0] pending;
   wire [31:0] unmasked;
   wire [31:0] irq_pend;
   wire [31:0] fiq_pend;
   wire [31:0] wake_set;
   wire any_irq;
   wire any_fiq;
   wire any_wake;
   wire addr_phase;
   wire rd_status;
   wire [`EVT_WIDTH-1:0] evt_set;

   // register offset match, used by both write and read decode
   function sel_reg;
      input [`ADDR_BITS-1:0] a;
      input [`ADDR_BITS-1:0] ofs;
      begin
         sel_reg = (a == ofs);
      end
   endfunction

   // source lines come from other clock domains
   irq_source_sync #(
      .WIDTH(NUM_SRC)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(irq_src),
      .sync_out(src_sync)
   );

   // reserved source positions never show as pending
   assign pending = src_sync & `SRC_VALID_MASK;
   assign unmasked = pending & mask_ff;
   assign fiq_pend = unmasked & route_ff;
   assign irq_pend = unmasked & ~route_ff;
   assign any_fiq = |fiq_pend;
   assign any_irq = |irq_pend;

   // wake source set: mask honoured only with disable bit set
   assign wake_set = ctl_dim_ff ? unmasked : pending;
   assign any_wake = idle_mode & (|wake_set);

   // processor lines registered; fast wins where core must choose
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_irq <= 1'b0;
         cpu_fiq <= 1'b0;
         idle_wake <= 1'b0;
      end else begin
         cpu_fiq <= any_fiq;
         cpu_irq <= any_irq;
         idle_wake <= any_wake;
      end
   end

   // bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & hready & htrans[1];

   // capture address phase for the following data phase
   always @* begin
      nxt_addr = haddr[`ADDR_BITS-1:0];
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= {`ADDR_BITS{1'b0}};
      end else begin
         wr_pend_ff <= addr_phase & hwrite;
         rd_pend_ff <= addr_phase & ~hwrite;
         if (addr_phase) begin
            addr_ff <= nxt_addr;
         end
      end
   end

   // configuration registers written in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= `MASK_RESET;
         route_ff <= `ROUTE_RESET;
         ctl_dim_ff <= 1'b0;
         evt_mask_ff <= {`EVT_WIDTH{1'b0}};
      end else if (wr_pend_ff) begin
         if (sel_reg(addr_ff, `OFS_MASK)) begin
            mask_ff <= hwdata & `SRC_VALID_MASK;
         end
         if (sel_reg(addr_ff, `OFS_ROUTE)) begin
            route_ff <= hwdata & `SRC_VALID_MASK;
         end
         if (sel_reg(addr_ff, `OFS_CONTROL)) begin
            ctl_dim_ff <= hwdata[`IDLE_MASK_DISABLE_BIT];
         end
         if (sel_reg(addr_ff, `OFS_EVT_MASK)) begin
            evt_mask_ff <= hwdata[`EVT_WIDTH-1:0];
         end
      end
   end

   // read data decided at the address phase so it stands in the data phase
   always @* begin
      nxt_rdata = 32'h00000000;
      case (1'b1)
         sel_reg(nxt_addr, `OFS_PENDING): nxt_rdata = pending;
         sel_reg(nxt_addr, `OFS_MASK): nxt_rdata = mask_ff;
         sel_reg(nxt_addr, `OFS_ROUTE): nxt_rdata = route_ff;
         sel_reg(nxt_addr, `OFS_CONTROL): nxt_rdata = {31'h00000000, ctl_dim_ff};
         sel_reg(nxt_addr, `OFS_IRQ_PEND): nxt_rdata = irq_pend;
         sel_reg(nxt_addr, `OFS_FIQ_PEND): nxt_rdata = fiq_pend;
         sel_reg(nxt_addr, `OFS_EVT_STATUS): nxt_rdata = {29'h00000000, evt_status_ff};
         sel_reg(nxt_addr, `OFS_EVT_MASK): nxt_rdata = {29'h00000000, evt_mask_ff};
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase & ~hwrite) begin
         hrdata <= nxt_rdata;
      end
   end

   // rising edges of the processor lines and of wake are events
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_irq_d_ff <= 1'b0;
         cpu_fiq_d_ff <= 1'b0;
         wake_d_ff <= 1'b0;
      end else begin
         cpu_irq_d_ff <= cpu_irq;
         cpu_fiq_d_ff <= cpu_fiq;
         wake_d_ff <= idle_wake;
      end
   end

   assign evt_set = {idle_wake & ~wake_d_ff, cpu_fiq & ~cpu_fiq_d_ff, cpu_irq & ~cpu_irq_d_ff};
   assign rd_status = rd_pend_ff & sel_reg(addr_ff, `OFS_EVT_STATUS);

   // read clears only the bits it returned (hrdata holds them in the data phase);
   // an event latched at the address edge was not returned and must survive, and set beats clear
   always @* begin
      nxt_evt_status = rd_status ? ((evt_status_ff & ~hrdata[`EVT_WIDTH-1:0]) | evt_set) : (evt_status_ff | evt_set);
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_status_ff <= {`EVT_WIDTH{1'b0}};
      end else begin
         evt_status_ff <= nxt_evt_status;
      end
   end

   assign evt_irq = |(evt_status_ff & evt_mask_ff);

endmodule

`default_nettype wire

// ===== rtl/irq_route_consts.vh
// register offsets, field positions and reset values for the interrupt routing block
// assumes inclusion by bare name from design files; definitions only
`ifndef IRQ_ROUTE_CONSTS_VH
`define IRQ_ROUTE_CONSTS_VH

// register byte offsets (word aligned)
`define OFS_PENDING 12'h000
`define OFS_MASK 12'h004
`define OFS_ROUTE 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_IRQ_PEND 12'h010
`define OFS_FIQ_PEND 12'h014
`define OFS_EVT_STATUS 12'h018
`define OFS_EVT_MASK 12'h01C
`define ADDR_BITS 12

// sources that exist: 8..14 and 17..31
`define SRC_VALID_MASK 32'hFFFE7F00
`define ROUTE_RESET 32'h00000000
`define MASK_RESET 32'h00000000
`define CONTROL_RESET 32'h00000000
`define IDLE_MASK_DISABLE_BIT 0

// event status layout
`define EVT_IRQ_BIT 0
`define EVT_FIQ_BIT 1
`define EVT_WAKE_BIT 2
`define EVT_WIDTH 3

`endif

// ===== rtl/irq_source_sync.v
// two-flop synchroniser for the interrupt source lines
// assumes sources are asynchronous levels from other units
`timescale 1ns/100ps
`default_nettype none

module irq_source_sync #(
   parameter WIDTH = 32
) (
   input wire hclk,
   input wire hresetn,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // first stage feeds only the second stage
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ===== dv/irq_route_checker.sv
// port checker for the routing block
// assumes it is bound to the top design module
`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.vh"
module irq_route_checker #(
   parameter NUM_SRC = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [NUM_SRC-1:0] irq_src,
   input wire logic idle_mode,
   input wire logic cpu_irq,
   input wire logic cpu_fiq,
   input wire logic idle_wake,
   input wire logic evt_irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // outputs need a real source three edges back; reserved lines never count
   AST_IRQ_CAUSE: assert property (cpu_irq |-> ($past(irq_src, 3) & `SRC_VALID_MASK) != 0)
      else $error("normal line without a source");
   AST_FIQ_CAUSE: assert property (cpu_fiq |-> ($past(irq_src, 3) & `SRC_VALID_MASK) != 0)
      else $error("fast line without a source");
   AST_QUIET: assert property (((irq_src & `SRC_VALID_MASK) == 0)[*4] |-> !cpu_irq && !cpu_fiq)
      else $error("line raised with no source");
   AST_WAKE_CAUSE: assert property (idle_wake |-> ($past(irq_src, 3) & `SRC_VALID_MASK) != 0)
      else $error("wake without a source");
   AST_WAKE_IDLE: assert property ((!idle_mode)[*2] |-> !idle_wake)
      else $error("wake outside idle");
   AST_RESET_OUT: assert property ($rose(hresetn) |-> !cpu_irq && !cpu_fiq && !idle_wake && !evt_irq)
      else $error("output high after reset");
   AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
      else $error("read data moved without a read");
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   cover property ($rose(cpu_fiq));
   cover property ($rose(idle_wake));
   cover property (cpu_irq && cpu_fiq);
endmodule
bind irq_route_idle_wake irq_route_checker #(.NUM_SRC(NUM_SRC)) chk_i (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq_src, .idle_mode, .cpu_irq, .cpu_fiq, .idle_wake, .evt_irq);
`default_nettype wire

// ===== dv/cpu_core_model.sv
// core model: records which interrupt line it would take
// assumes both lines are levels on hclk
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic irq,
   input wire logic fiq,
   output logic [1:0] taken_ff
);
   // fast wins when both stand, so a normal one waits
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) taken_ff <= 2'h0;
      else taken_ff <= fiq ? 2'h2 : {1'b0, irq};
   end
endmodule
`default_nettype wire

// ===== dv/irq_route_idle_wake_tb_top.sv
// self-checking bench for the routing block
// assumes the checker binds itself and hready loops back from hreadyout
`timescale 1ns/100ps
`default_nettype none
`include "irq_route_consts.vh"
module irq_route_idle_wake_tb_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, idle_mode = 0;
   logic [31:0] haddr = 0, hwdata = 0, irq_src = 0, rd, s = 38;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   wire hreadyout, hresp, cpu_irq, cpu_fiq, idle_wake, evt_irq;
   wire [31:0] hrdata;
   wire [1:0] taken;
   int n_mismatch = 0, n_compared = 0;
   irq_route_idle_wake irq_route_idle_wake_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_src, .idle_mode, .cpu_irq, .cpu_fiq, .idle_wake, .evt_irq);
   cpu_core_model cpu_core_model_i (.hclk, .hresetn, .irq(cpu_irq), .fiq(cpu_fiq), .taken_ff(taken));
   // 50 MHz clock
   initial forever #10 hclk = ~hclk;
   function logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer; hready is never assumed, only waited for
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // program, apply sources, then compare with the routing worked out here
   task run(input logic [31:0] sv, input logic [31:0] mv, input logic [31:0] rv, input logic idle_mask_disable, input logic idl);
      logic [31:0] v;
      logic ei, ef;
      v = sv & `SRC_VALID_MASK;
      ei = |(v & mv & ~rv);
      ef = |(v & mv & rv);
      xfer(1, `OFS_MASK, mv);
      xfer(1, `OFS_ROUTE, rv);
      xfer(1, `OFS_CONTROL, {31'h0, idle_mask_disable});
      irq_src <= sv;
      idle_mode <= idl;
      repeat (6) @(posedge hclk);
      #1;
      chk(cpu_irq, ei);
      chk(cpu_fiq, ef);
      chk(idle_wake, idl & |(v & (idle_mask_disable ? mv : 32'hFFFFFFFF)));
      chk(taken, {ef, ei & ~ef});
      chk(evt_irq, 0);
      @(posedge hclk);
      // pending views: normal and fast split by the route bits, raw view ignores the mask
      xfer(0, `OFS_IRQ_PEND, 0);
      chk(rd, v & mv & ~rv);
      xfer(0, `OFS_FIQ_PEND, 0);
      chk(rd, v & mv & rv);
      xfer(0, `OFS_PENDING, 0);
      chk(rd, v);
   endtask
   task complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      complete_run;
   end
   // main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      for (int a = 4; a <= 32; a += 4) begin
         xfer(0, a[11:0], 0);
         chk(rd, 0);
      end
      xfer(1, `OFS_CONTROL, 32'hFFFFFFFF);
      xfer(0, `OFS_CONTROL, 0);
      chk(rd, 1);
      xfer(1, `OFS_ROUTE, 32'hFFFFFFFF);
      xfer(0, `OFS_ROUTE, 0);
      chk(rd, `SRC_VALID_MASK);
      xfer(1, `OFS_CONTROL, 1);
      hresetn <= 0;
      @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      xfer(0, `OFS_CONTROL, 0);
      chk(rd, 0);
      $display("reset and reserved bits done");
      run(32'h100, 0, 0, 0, 1);
      run(32'h100, 0, 0, 1, 1);
      run(32'hFF, 32'hFFFFFFFF, 0, 0, 1);
      run(32'h20100, 32'hFFFFFFFF, 32'h20000, 0, 0);
      repeat (20) run(xs(), xs(), xs(), s[3], s[7]);
      run(0, 32'hFFFFFFFF, 32'hFFFFFFFF, 0, 0);
      $display("routing done");
      xfer(0, `OFS_EVT_STATUS, 0);
      xfer(1, `OFS_EVT_MASK, 32'h2);
      irq_src <= 32'h100;
      repeat (6) @(posedge hclk);
      #1;
      chk(evt_irq, 1);
      @(posedge hclk);
      xfer(0, `OFS_EVT_STATUS, 0);
      chk(rd, 32'h2);
      #1;
      chk(evt_irq, 0);
      $display("event interrupt done");
      complete_run;
   end
endmodule
`default_nettype wire
